// File: rdsg_defs.vh
/*
 Constants of the reset, unit-loss, panel-stop and write-guard block:
 register offsets, field positions, reset values, codes and timing.
 Assumes a 50 MHz clock and a 12-bit APB byte address.
*/
`ifndef RDSG_DEFS_VH
`define RDSG_DEFS_VH

// ************************************************
// Register offsets
// ************************************************
`define RDSG_OFS_SEL     12'h000
`define RDSG_OFS_OPT     12'h004
`define RDSG_OFS_PARAM   12'h008
`define RDSG_OFS_STATUS  12'h00c

// ************************************************
// Fields and reset values
// ************************************************
`define RDSG_WG_LSB      8
`define RDSG_SEL_RST     5'h0e
`define RDSG_SEL_LO_MAX  5'h03
`define RDSG_SEL_HI_MIN  5'h0e
`define RDSG_SEL_HI_MAX  5'h11
`define RDSG_WG_RST      2'h0
`define RDSG_WG_MAX      2'h2
`define RDSG_WG_STOPPED  2'h0
`define RDSG_WG_LOCKED   2'h1
`define RDSG_WG_ANY      2'h2

// ************************************************
// Operation modes
// ************************************************
`define RDSG_MODE_UNIT   2'h0
`define RDSG_MODE_EXT    2'h1
`define RDSG_MODE_NET    2'h2

// ************************************************
// Parameter access classes and requests
// ************************************************
`define RDSG_CLS_NORMAL  0
`define RDSG_CLS_EXEMPT  1
`define RDSG_CLS_CARRIER 2
`define RDSG_CLS_RDSS    3
`define RDSG_CLS_WGS     4
`define RDSG_CLS_DISP    5
`define RDSG_CLS_CLEAR   6
`define RDSG_OP_NORMAL   3'h0
`define RDSG_OP_EXEMPT   3'h1
`define RDSG_OP_CARRIER  3'h2
`define RDSG_OP_CLEAR    3'h4
`define RDSG_OP_ALLCLR   3'h5

// ************************************************
// Timing
// ************************************************
`define RDSG_CLK_KHZ     50000
`define RDSG_LOSS_MS     1000
`define RDSG_LOSS_CYC    (`RDSG_LOSS_MS * `RDSG_CLK_KHZ)

`endif

// File: rdsg_loss_timer.v
/*
 Operator-unit loss timer: counts cycles of continuous absence and
 flags expiry once the absence has lasted beyond the limit.
 Assumes a synchronous presence level and a synchronous reset.
*/
`timescale 1ns/10ps

module rdsg_loss_timer #(
    parameter [25:0] LIMIT = 26'd50000000
) (
    // Clock and reset
    input  wire        clk,
    input  wire        srst,
    // Control
    input  wire        arm,
    input  wire        present,
    // Result
    output wire        expired
);

    reg  [25:0] cnt_ff;
    reg  [25:0] nxt_cnt;
    reg         exp_ff;

    always @* begin
        nxt_cnt = cnt_ff;
        if (!arm || present) begin
            nxt_cnt = 26'h0;
        end else if (cnt_ff != LIMIT) begin
            nxt_cnt = cnt_ff + 26'h1;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            cnt_ff <= 26'h0;
            exp_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            // Strictly longer than the limit before expiry
            exp_ff <= arm && !present && (cnt_ff == LIMIT);
        end
    end

    assign expired = exp_ff;

endmodule

// File: rdsg_wguard.v
/*
 Parameter write guard: decides, per access class, whether a parameter
 write or clear is allowed now. Purely combinational.
 Assumes run state and mode are synchronous to the caller's clock.
*/
`timescale 1ns/10ps
`include "rdsg_defs.vh"

module rdsg_wguard (
    // Settings
    input  wire [1:0]  wg_sel,
    input  wire        disp_ext,
    // Drive state
    input  wire        running,
    input  wire        unit_mode,
    // Verdict per class
    output reg  [6:0]  ok
);

    reg free_wr;

    always @* begin
        free_wr = (wg_sel == `RDSG_WG_ANY) ||
                  ((wg_sel == `RDSG_WG_STOPPED) && !running && unit_mode);
        ok = 7'h0;
        ok[`RDSG_CLS_NORMAL]  = free_wr;
        ok[`RDSG_CLS_EXEMPT]  = 1'b1;
        ok[`RDSG_CLS_CARRIER] = (wg_sel == `RDSG_WG_ANY) ||
                                ((wg_sel == `RDSG_WG_STOPPED) && unit_mode);
        ok[`RDSG_CLS_RDSS]    = disp_ext;
        ok[`RDSG_CLS_WGS]     = disp_ext;
        ok[`RDSG_CLS_DISP]    = 1'b1;
        ok[`RDSG_CLS_CLEAR]   = free_wr;
    end

endmodule

// File: rdsg_top.v
/*
 Reset acceptance, operator-unit loss detection, panel stop and
 parameter write guard of a motor drive controller, with APB registers.
 Assumes all inputs synchronous to REF_CLK; keys and reset requests are
 one-cycle pulses, run and mode inputs are levels.
*/
`timescale 1ns/10ps
`include "rdsg_defs.vh"

// Operation
// - Selector accepts only 0-3 and 14-17; defaults to 14.
// - Selector 1,3,15,17: pin or link reset honoured only while tripped.
// - Reset taken while running shuts drive output off; motor coasts.
// - Every performed reset clears thermal and brake duty accumulations.
// - Operator-unit reset key works only while tripped, any selector value.
// - Detection selected: unit absent over 1s trips with unit-loss fault.
// - Selector 0,1,14,15: unit absence is ignored, no fault.
// - Unit absent since power-on is never a loss fault.
// - Unit jog with continue-on-loss: losing unit decelerates motor to stop.
// - Serial link on unit connector disables loss detection only.
// - Selector 14-17: stop key decelerates in every operation mode.
// - Panel stop enters panel-stop state, shows it, raises no fault.
// - Selector 0-3: no panel-stop state; stop key acts in unit mode only.
// - Panel-stop state left by same-unit reset, power reset or reset pin.
// - Panel stop in external mode decelerates even if coast selected.
// - Unit mode: stop from non-source unit enters panel-stop state.
// - Command source 9999: detachable unit outranks built-in panel.
// - Selector writable running under guard 0/1; clears keep it.
// - Guard defaults 0: 0 stopped only, 1 no writes, 2 always.
// - Guard 0: stopped unit mode only; carrier writes need unit mode.
// - Selector and guard settable only with extended display at 0.
// - Guard 1 refuses writes and clears except exempt ones.
module rdsg_top #(
    parameter [25:0] LOSS_CYCLES = `RDSG_LOSS_CYC
) (
    // Clock and reset
    input  wire        REF_CLK,
    input  wire        SRST,
    // APB slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output wire [31:0] PRDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    // Drive state
    input  wire        RUNNING,
    input  wire [1:0]  MODE,
    input  wire        JOG_ACTIVE,
    input  wire        START_IN,
    input  wire        FAULT_IN,
    // Operator panel and unit
    input  wire        UNIT_PRESENT,
    input  wire        LINK_ON_UNIT,
    input  wire        PANEL_STOP_KEY,
    input  wire        UNIT_STOP_KEY,
    input  wire        PANEL_PS_RESET_KEY,
    input  wire        UNIT_PS_RESET_KEY,
    input  wire        UNIT_RESET_KEY,
    // Reset requests
    input  wire        RESET_INPUT_PIN,
    input  wire        LINK_RESET_REQ,
    // Protection outputs
    output wire        TRIPPED,
    output wire        UNIT_LOSS_FAULT,
    output wire        DRIVE_OFF,
    output wire        CLR_THERMAL,
    output wire        CLR_BRAKE_DUTY,
    output wire        DECEL_STOP,
    output wire        PANEL_STOP_STATE
);

    // ************************************************
    // Selector decoding
    // ************************************************
    function sel_legal;
        input [4:0] v;
        begin
            sel_legal = (v <= `RDSG_SEL_LO_MAX) ||
                        ((v >= `RDSG_SEL_HI_MIN) && (v <= `RDSG_SEL_HI_MAX));
        end
    endfunction

    function sel_fault_only;
        input [4:0] v;
        begin
            sel_fault_only = v[0];
        end
    endfunction

    function sel_detect;
        input [4:0] v;
        begin
            sel_detect = (v < `RDSG_SEL_HI_MIN) ? v[1] : v[4];
        end
    endfunction

    function sel_ps_en;
        input [4:0] v;
        begin
            sel_ps_en = (v >= `RDSG_SEL_HI_MIN);
        end
    endfunction

    // ************************************************
    // State
    // ************************************************
    reg  [4:0]  sel_ff;
    reg  [1:0]  wg_ff;
    reg         disp_simple_ff;
    reg         coast_ff;
    reg         cmd_prio_ff;
    reg         wr_ok_ff;
    reg         wr_ref_ff;
    reg         seen_ff;
    reg         tripped_ff;
    reg         loss_ff;
    reg         ps_ff;
    reg         ps_src_ff;
    reg         decel_ff;
    reg         drive_off_ff;
    reg         clr_ff;
    reg         pready_ff;
    reg         pslverr_ff;
    reg  [31:0] prdata_ff;

    wire        loss_exp;
    wire [6:0]  ok;
    wire        unit_mode = (MODE == `RDSG_MODE_UNIT);

    // ************************************************
    // Reset acceptance
    // ************************************************
    wire reset_req = RESET_INPUT_PIN || LINK_RESET_REQ;
    wire reset_ok  = reset_req && (!sel_fault_only(sel_ff) || tripped_ff);
    wire key_ok    = UNIT_RESET_KEY && tripped_ff;
    wire reset_do  = reset_ok || key_ok;

    // ************************************************
    // Unit loss
    // ************************************************
    // Arming waits for a first sighting so an absent unit at power-on is fine
    wire loss_arm = sel_detect(sel_ff) && !LINK_ON_UNIT &&
                    seen_ff && !loss_ff;

    rdsg_loss_timer #(
        .LIMIT   (LOSS_CYCLES)
    ) u_timer (
        .clk     (REF_CLK),
        .srst    (SRST),
        .arm     (loss_arm),
        .present (UNIT_PRESENT),
        .expired (loss_exp)
    );

    // ************************************************
    // Stop keys and command source
    // ************************************************
    wire unit_src = cmd_prio_ff && UNIT_PRESENT;
    wire any_stop = PANEL_STOP_KEY || UNIT_STOP_KEY;
    wire nonsrc   = (PANEL_STOP_KEY && unit_src) ||
                    (UNIT_STOP_KEY && !unit_src);
    wire ps_en    = sel_ps_en(sel_ff);
    wire ps_enter = ps_en && ((!unit_mode && any_stop) ||
                              (unit_mode && nonsrc));
    wire jog_loss = JOG_ACTIVE && unit_mode && !UNIT_PRESENT &&
                    seen_ff && !sel_detect(sel_ff);
    wire decel_req = (ps_en && any_stop) ||
                     (!ps_en && unit_mode && any_stop) ||
                     jog_loss;
    // Only the unit that stopped the drive may clear it, with start dropped
    wire ps_key   = ps_src_ff ? UNIT_PS_RESET_KEY : PANEL_PS_RESET_KEY;
    wire ps_exit  = RESET_INPUT_PIN ||
                    (ps_key && !START_IN && !RUNNING);

    // ************************************************
    // Protection state
    // ************************************************
    always @(posedge REF_CLK) begin
        if (SRST) begin
            seen_ff      <= 1'b0;
            tripped_ff   <= 1'b0;
            loss_ff      <= 1'b0;
            ps_ff        <= 1'b0;
            ps_src_ff    <= 1'b0;
            decel_ff     <= 1'b0;
            drive_off_ff <= 1'b0;
            clr_ff       <= 1'b0;
        end else begin
            seen_ff <= seen_ff || UNIT_PRESENT;
            // Trip events win over a reset in the same cycle
            if (FAULT_IN || loss_exp) begin
                tripped_ff <= 1'b1;
            end else if (reset_do) begin
                tripped_ff <= 1'b0;
            end
            if (loss_exp) begin
                loss_ff <= 1'b1;
            end else if (reset_do) begin
                loss_ff <= 1'b0;
            end
            // Panel stop is a state, not a trip
            if (ps_enter) begin
                ps_ff     <= 1'b1;
                ps_src_ff <= UNIT_STOP_KEY;
            end else if (ps_exit) begin
                ps_ff <= 1'b0;
            end
            // Coast selection is not consulted here
            decel_ff     <= decel_req || (decel_ff && RUNNING);
            drive_off_ff <= reset_do && RUNNING;
            clr_ff       <= reset_do;
        end
    end

    // ************************************************
    // Write guard
    // ************************************************
    rdsg_wguard u_guard (
        .wg_sel    (wg_ff),
        .disp_ext  (!disp_simple_ff),
        .running   (RUNNING),
        .unit_mode (unit_mode),
        .ok        (ok)
    );

    // ************************************************
    // APB slave
    // ************************************************
    wire setup  = PSEL && !PENABLE;
    wire access = PSEL && PENABLE && pready_ff;
    wire wr     = access && PWRITE;
    wire [2:0] op = PWDATA[2:0];
    wire [4:0] wsel = PWDATA[4:0];
    wire [1:0] wwg  = PWDATA[`RDSG_WG_LSB+1:`RDSG_WG_LSB];

    reg  op_ok;
    reg  op_known;

    always @* begin
        op_ok    = 1'b0;
        op_known = 1'b1;
        case (op)
            `RDSG_OP_NORMAL:  op_ok = ok[`RDSG_CLS_NORMAL];
            `RDSG_OP_EXEMPT:  op_ok = ok[`RDSG_CLS_EXEMPT];
            `RDSG_OP_CARRIER: op_ok = ok[`RDSG_CLS_CARRIER];
            `RDSG_OP_CLEAR:   op_ok = ok[`RDSG_CLS_CLEAR];
            `RDSG_OP_ALLCLR:  op_ok = ok[`RDSG_CLS_CLEAR];
            default:          op_known = 1'b0;
        endcase
    end

    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `RDSG_OFS_SEL) || (a == `RDSG_OFS_OPT) ||
                     (a == `RDSG_OFS_PARAM) || (a == `RDSG_OFS_STATUS);
        end
    endfunction

    always @(posedge REF_CLK) begin
        if (SRST) begin
            sel_ff         <= `RDSG_SEL_RST;
            wg_ff          <= `RDSG_WG_RST;
            disp_simple_ff <= 1'b0;
            coast_ff       <= 1'b0;
            cmd_prio_ff    <= 1'b1;
            wr_ok_ff       <= 1'b0;
            wr_ref_ff      <= 1'b0;
        end else if (wr) begin
            case (PADDR)
                `RDSG_OFS_SEL: begin
                    // Illegal values are dropped, keeping the old setting
                    if (ok[`RDSG_CLS_RDSS] && sel_legal(wsel)) begin
                        sel_ff <= wsel;
                    end
                    if (ok[`RDSG_CLS_WGS] && (wwg <= `RDSG_WG_MAX)) begin
                        wg_ff <= wwg;
                    end
                end
                `RDSG_OFS_OPT: begin
                    disp_simple_ff <= PWDATA[0];
                    if (ok[`RDSG_CLS_NORMAL]) begin
                        coast_ff    <= PWDATA[1];
                        cmd_prio_ff <= PWDATA[2];
                    end
                end
                `RDSG_OFS_PARAM: begin
                    wr_ok_ff  <= op_known && op_ok;
                    wr_ref_ff <= op_known && !op_ok;
                    if (op_ok && op[2]) begin
                        // Clears leave the reset/detect/stop selector alone
                        disp_simple_ff <= 1'b0;
                        coast_ff       <= 1'b0;
                        cmd_prio_ff    <= 1'b1;
                    end
                end
                default: begin
                    wr_ok_ff <= wr_ok_ff;
                end
            endcase
        end
    end

    // Zero-wait answer: ready rises for the access cycle only
    always @(posedge REF_CLK) begin
        if (SRST) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup && !mapped(PADDR);
            prdata_ff  <= 32'h0;
            if (setup && !PWRITE) begin
                case (PADDR)
                    `RDSG_OFS_SEL:
                        prdata_ff <= {22'h0, wg_ff, 3'h0, sel_ff};
                    `RDSG_OFS_OPT:
                        prdata_ff <= {29'h0, cmd_prio_ff, coast_ff, disp_simple_ff};
                    `RDSG_OFS_PARAM:
                        prdata_ff <= {30'h0, wr_ref_ff, wr_ok_ff};
                    `RDSG_OFS_STATUS:
                        prdata_ff <= {26'h0, seen_ff, decel_ff, ps_src_ff,
                                      ps_ff, loss_ff, tripped_ff};
                    default:
                        prdata_ff <= 32'h0;
                endcase
            end
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign PRDATA           = prdata_ff;
    assign PREADY           = pready_ff;
    assign PSLVERR          = pslverr_ff;
    assign TRIPPED          = tripped_ff;
    assign UNIT_LOSS_FAULT  = loss_ff;
    assign DRIVE_OFF        = drive_off_ff;
    assign CLR_THERMAL      = clr_ff;
    assign CLR_BRAKE_DUTY   = clr_ff;
    assign DECEL_STOP       = decel_ff;
    assign PANEL_STOP_STATE = ps_ff;

endmodule

// File: rdsg_props.sv
/*
 Checker of rdsg_top: APB timing, reset acceptance, unit loss and
 panel stop relations, seen at the top ports only.
 Assumes it is bound to rdsg_top with the same LOSS_CYCLES.
*/
`timescale 1ns/10ps
module rdsg_props #(
    parameter [25:0] LOSS_CYCLES = 26'd50000000
) (
    // Clock and reset
    input wire        REF_CLK,
    input wire        SRST,
    // APB
    input wire        PSEL,
    input wire        PENABLE,
    input wire [31:0] PRDATA,
    input wire        PREADY,
    input wire        PSLVERR,
    // Drive state and requests
    input wire        RUNNING,
    input wire        FAULT_IN,
    input wire        UNIT_PRESENT,
    input wire        PANEL_STOP_KEY,
    input wire        UNIT_STOP_KEY,
    input wire        PANEL_PS_RESET_KEY,
    input wire        UNIT_PS_RESET_KEY,
    input wire        UNIT_RESET_KEY,
    input wire        RESET_INPUT_PIN,
    input wire        LINK_RESET_REQ,
    // Protection outputs
    input wire        TRIPPED,
    input wire        UNIT_LOSS_FAULT,
    input wire        DRIVE_OFF,
    input wire        CLR_THERMAL,
    input wire        CLR_BRAKE_DUTY,
    input wire        PANEL_STOP_STATE
);
    logic [26:0] absent_ff;
    logic [26:0] nxt_absent;

    // ****************
    // Absence counter
    // ****************
    // Counts every absence, so it never undercounts the design's timer
    always @* begin
        nxt_absent = absent_ff + 27'h1;
        if (UNIT_PRESENT)
            nxt_absent = 27'h0;
    end
    always @(posedge REF_CLK) begin
        if (SRST)
            absent_ff <= 27'h0;
        else
            absent_ff <= nxt_absent;
    end

    // ****************
    // Properties
    // ****************
    default clocking dc @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    sequence setup_s;
        PSEL && !PENABLE;
    endsequence
    sequence access_s;
        PSEL && PENABLE && PREADY;
    endsequence

    apb_ready_a: assert property (setup_s |=> access_s ##1 !PREADY)
        else $error("ready not in the single access cycle");
    prdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside access cycle");
    slverr_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("error flag without ready");
    clr_pair_a: assert property (CLR_THERMAL == CLR_BRAKE_DUTY)
        else $error("clear pulses differ");
    clr_cause_a: assert property (CLR_THERMAL |-> $past(RESET_INPUT_PIN) || $past(LINK_RESET_REQ) || $past(UNIT_RESET_KEY))
        else $error("clear without reset request");
    drive_off_a: assert property (DRIVE_OFF == (CLR_THERMAL && $past(RUNNING)))
        else $error("drive off not tied to reset while running");
    unit_key_block_a: assert property (UNIT_RESET_KEY && !TRIPPED && !RESET_INPUT_PIN && !LINK_RESET_REQ |=> !CLR_THERMAL)
        else $error("unit reset key honoured while not tripped");
    unit_key_clear_a: assert property (UNIT_RESET_KEY && TRIPPED && !FAULT_IN && UNIT_PRESENT |=> !TRIPPED && CLR_THERMAL)
        else $error("unit reset key ignored while tripped");
    loss_time_a: assert property ($rose(UNIT_LOSS_FAULT) |-> absent_ff > {1'b0, LOSS_CYCLES})
        else $error("unit loss fault too early");
    loss_trip_a: assert property ($rose(UNIT_LOSS_FAULT) |-> ##[0:1] TRIPPED)
        else $error("unit loss fault without trip");
    ps_entry_a: assert property ($rose(PANEL_STOP_STATE) |-> ($past(PANEL_STOP_KEY) || $past(UNIT_STOP_KEY)) && !$rose(TRIPPED))
        else $error("panel stop entered wrongly");
    ps_exit_a: assert property ($fell(PANEL_STOP_STATE) |-> $past(RESET_INPUT_PIN) || $past(PANEL_PS_RESET_KEY) || $past(UNIT_PS_RESET_KEY))
        else $error("panel stop left without reset");
endmodule

bind rdsg_top rdsg_props #(.LOSS_CYCLES(LOSS_CYCLES)) u_props (.*);

// File: rdsg_op_model.sv
/*
 Operator panel and detachable unit model: presence, keys, start level.
 Assumes the bench calls its tasks; outputs change after rising edges.
*/
`timescale 1ns/10ps
module rdsg_op_model (
    // Clock
    input  wire        clk,
    // Unit, start and keys
    output logic       present,
    output logic       start,
    output logic [4:0] key
);
    // Keys: panel stop, unit stop, panel and unit stop reset, unit reset
    initial begin
        present = 1'b0;
        start   = 1'b1;
        key     = 5'h00;
    end
    task automatic plug(input logic v);
        @(posedge clk);
        present <= v;
    endtask
    task automatic press(input int k);
        @(posedge clk);
        key[k] <= 1'b1;
        @(posedge clk);
        key <= 5'h00;
    endtask
    task automatic restart;
        @(posedge clk);
        start <= 1'b0;
        press(2);
        @(posedge clk);
        start <= 1'b1;
    endtask
endmodule

// File: tb.sv
/*
 Self-checking bench of rdsg_top: registers, reset acceptance,
 unit loss, panel stop and write guard.
 Assumes rdsg_op_model and rdsg_props are compiled before it.
*/
`timescale 1ns/10ps
`include "rdsg_defs.vh"
module tb;
    localparam int LC = 20;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel;
    logic        pen;
    logic        pwr;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        running;
    logic [1:0]  mode;
    logic        jog;
    logic        link;
    logic [2:0]  tsig;
    logic [10:0] rows [10];
    logic [9:0]  grows [10];
    logic [4:0]  s;
    logic [2:0]  k;
    logic [2:0]  opc;
    logic [1:0]  wg;
    logic [1:0]  md;
    logic [1:0]  ex;
    logic        t;
    logic        r;
    logic        x;
    logic [31:0] q;
    logic        e;
    int          bad_count = 0;
    int          checks_done = 0;
    wire  [31:0] prdata;
    wire  [4:0]  key;
    wire         pready, pslverr, present, start;
    wire         tripped, loss, drive_off, clr_th, clr_bd, decel, ps_state;

    always #10 clk = ~clk;

    rdsg_op_model op (.clk(clk), .present(present), .start(start), .key(key));

    rdsg_top #(.LOSS_CYCLES(26'd20)) DUT (
        .REF_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .RUNNING(running), .MODE(mode), .JOG_ACTIVE(jog),
        .START_IN(start), .FAULT_IN(tsig[2]), .UNIT_PRESENT(present),
        .LINK_ON_UNIT(link), .PANEL_STOP_KEY(key[0]), .UNIT_STOP_KEY(key[1]),
        .PANEL_PS_RESET_KEY(key[2]), .UNIT_PS_RESET_KEY(key[3]),
        .UNIT_RESET_KEY(key[4]), .RESET_INPUT_PIN(tsig[0]),
        .LINK_RESET_REQ(tsig[1]), .TRIPPED(tripped), .UNIT_LOSS_FAULT(loss),
        .DRIVE_OFF(drive_off), .CLR_THERMAL(clr_th), .CLR_BRAKE_DUTY(clr_bd),
        .DECEL_STOP(decel), .PANEL_STOP_STATE(ps_state)
    );

    // ****************
    // Tasks
    // ****************
    task automatic chk(input logic [31:0] g, input logic [31:0] w);
        checks_done++;
        if (g !== w) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, w);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 8) begin
            n++;
            @(posedge clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        if (n == 8)
            bad_count++;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] w);
        apb(1'b0, a, 32'h0);
        chk(q, w);
    endtask
    // Kinds 0-4 are model keys; 5 pin, 6 link, 7 other fault
    task automatic req(input int kind);
        if (kind < 5)
            op.press(kind);
        else begin
            @(posedge clk);
            tsig[kind-5] <= 1'b1;
            @(posedge clk);
            tsig <= 3'h0;
        end
        #1;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        close_out;
    end

    // ****************
    // Main sequence
    // ****************
    initial begin
        {psel, pen, pwr, paddr, pwdata, running, mode, jog, link, tsig} <= '0;
        // Row: selector, tripped first, request kind, running, accepted
        rows = '{11'h397, 11'h3d4, 11'h3f9, 11'h458, 11'h0f5,
                 11'h058, 11'h01b, 11'h410, 11'h3b1, 11'h095};
        // Row: guard, running, mode, op, result {refused, ok}
        grows = '{10'h102, 10'h185, 10'h082, 10'h001, 10'h089,
                  10'h02a, 10'h2a1, 10'h112, 10'h116, 10'h015};
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd(`RDSG_OFS_SEL, 32'he);
        apb(1'b0, 12'h010, 32'h0);
        chk(q, 32'h0);
        chk(e, 1'b1);
        wr(`RDSG_OFS_SEL, 32'h10);
        cyc(LC + 8);
        chk(loss, 1'b0);
        op.plug(1'b1);
        foreach (rows[i]) begin
            {s, t, k, r, x} = rows[i];
            wr(`RDSG_OFS_SEL, {27'h0, s});
            running <= r;
            if (t)
                req(7);
            req(int'(k));
            chk(clr_th, x);
            chk(clr_bd, x);
            chk(drive_off, x & r);
            chk(tripped, t & ~x);
            running <= 1'b0;
            if (tripped === 1'b1)
                req(5);
        end
        wr(`RDSG_OFS_SEL, 32'h305);
        rd(`RDSG_OFS_SEL, 32'h2);
        wr(`RDSG_OFS_OPT, 32'h1);
        wr(`RDSG_OFS_SEL, 32'he);
        rd(`RDSG_OFS_SEL, 32'h2);
        wr(`RDSG_OFS_OPT, 32'h2);
        foreach (grows[i]) begin
            {wg, r, md, opc, ex} = grows[i];
            running <= r;
            mode    <= md;
            wr(`RDSG_OFS_SEL, {22'h0, wg, 8'h10});
            wr(`RDSG_OFS_PARAM, {29'h0, opc});
            rd(`RDSG_OFS_PARAM, {30'h0, ex});
        end
        running <= 1'b0;
        mode    <= 2'h0;
        rd(`RDSG_OFS_SEL, 32'h10);
        rd(`RDSG_OFS_OPT, 32'h4);
        op.plug(1'b0);
        cyc(LC - 5);
        op.plug(1'b1);
        op.plug(1'b0);
        cyc(LC - 5);
        chk(loss, 1'b0);
        cyc(10);
        chk(loss, 1'b1);
        chk(tripped, 1'b1);
        op.plug(1'b1);
        req(5);
        chk(tripped, 1'b0);
        for (int j = 0; j < 2; j++) begin
            link <= (j == 0);
            wr(`RDSG_OFS_SEL, (j == 0) ? 32'h10 : 32'he);
            op.plug(1'b0);
            cyc(LC + 8);
            chk(loss, 1'b0);
            op.plug(1'b1);
        end
        link    <= 1'b0;
        running <= 1'b1;
        jog     <= 1'b1;
        op.plug(1'b0);
        cyc(LC + 8);
        chk(decel, 1'b1);
        op.plug(1'b1);
        running <= 1'b0;
        jog     <= 1'b0;
        cyc(3);
        chk(decel, 1'b0);
        // Coast chosen and unit priority set before the external stop
        wr(`RDSG_OFS_OPT, 32'h6);
        mode    <= 2'h1;
        running <= 1'b1;
        req(0);
        chk(ps_state, 1'b1);
        chk(decel, 1'b1);
        chk(tripped, 1'b0);
        rd(`RDSG_OFS_STATUS, 32'h34);
        running <= 1'b0;
        req(3);
        chk(ps_state, 1'b1);
        op.restart;
        cyc(1);
        chk(ps_state, 1'b0);
        mode    <= 2'h0;
        running <= 1'b1;
        req(0);
        chk(ps_state, 1'b1);
        req(5);
        chk(ps_state, 1'b0);
        req(1);
        chk(ps_state, 1'b0);
        chk(decel, 1'b1);
        wr(`RDSG_OFS_SEL, 32'h2);
        running <= 1'b0;
        cyc(3);
        running <= 1'b1;
        for (int j = 1; j >= 0; j--) begin
            mode <= j[1:0];
            req(0);
            chk(decel, j == 0);
            chk(ps_state, 1'b0);
        end
        close_out;
    end
endmodule
